/* File: umc_regs.svh */
// register map, field positions and reset values of the modem control block
// assumes: included by the package and by the design module
//
// What this block does
// RULE1: control bit 7 selects divide-by-four prescaler
// RULE2: control bit 6 opens threshold/trigger register access
// RULE3: control bit 5 enables Xon-any
// RULE4: bits 7..5 writable only with feature enable
// RULE5: control bit 4 loops transmit into receive
// RULE6: loopback maps control bits into status 7..4
// RULE7: control bit 3 drives general output, inverted
// RULE8: control bit 2 enables FIFO-ready register
// RULE9: control bit 1 drives RTS, inverted
// RULE10: automatic flow control overrides RTS control bit
// RULE11: control bit 0 drives DTR, inverted
// RULE12: status 7..4 are complemented modem inputs
// RULE13: CD change sets status 3, read clears
// RULE14: RI rising sets status 2, read clears
// RULE15: DSR change sets status 1, read clears
// RULE16: CTS change sets status 0, read clears
// RULE17: modem interrupt only with configuration enable bit 1
// RULE18: modem inputs synchronised before change detection
`ifndef UMC_REGS_SVH
`define UMC_REGS_SVH

// ===========================================================
// register addresses
`define UMC_ADDR_W 3
`define UMC_ADDR_MCR 3'h0
`define UMC_ADDR_MSR 3'h1
`define UMC_ADDR_CFG 3'h2
`define UMC_ADDR_IST 3'h3
`define UMC_ADDR_IMSK 3'h4

// ===========================================================
// modem control fields
`define UMC_MCR_CLKSEL 7
`define UMC_MCR_TCRSEL 6
`define UMC_MCR_XONANY 5
`define UMC_MCR_LOOP 4
`define UMC_MCR_GPO 3
`define UMC_MCR_FRDY 2
`define UMC_MCR_RTS 1
`define UMC_MCR_DTR 0
`define UMC_MCR_PROT_HI 7
`define UMC_MCR_PROT_LO 5

// ===========================================================
// own configuration fields
`define UMC_CFG_W 3
`define UMC_CFG_EFR_WE 0
`define UMC_CFG_IER_MS 1
`define UMC_CFG_AUTORTS 2

// ===========================================================
// line index order: status and delta bit positions
`define UMC_LN_CTS 0
`define UMC_LN_DSR 1
`define UMC_LN_RI 2
`define UMC_LN_CD 3
`define UMC_LN_RX 4
`define UMC_NLN 4
`define UMC_NSYNC 5

// ===========================================================
// reset values
`define UMC_RST_MCR 8'h00
`define UMC_RST_CFG 3'h0
`define UMC_RST_NIB 4'h0
`define UMC_RST_SYNC 5'h1F
`define UMC_RST_LVL 4'hF
`define UMC_RST_CNT 8'h00
`define UMC_RST_BYTE 8'h00
`define UMC_PRESC_DIV 4

`endif

/* File: umc_pkg.sv */
// state type of the modem control block
// assumes: umc_regs.svh is on the include path
`include "umc_regs.svh"

package umc_pkg;

  // ===========================================================
  // whole state of the block
  typedef struct packed {
    logic [7:0] modem_control;
    logic [`UMC_CFG_W-1:0] cfg;
    logic [`UMC_NLN-1:0] delta;
    logic [`UMC_NLN-1:0] ist;
    logic [`UMC_NLN-1:0] imask;
    logic [`UMC_NSYNC-1:0] meta;
    logic [`UMC_NSYNC-1:0] sync;
    logic [`UMC_NLN-1:0] prev;
    logic [7:0] cnt;
    logic rts_n;
    logic dtr_n;
    logic gpo_n;
    logic baud_en;
    logic tcr_sel;
    logic xon_any;
    logic frdy_en;
    logic loop;
    logic rx;
    logic [7:0] rd_data;
    logic irq;
    logic modem_irq;
  } umc_state_type;

endpackage : umc_pkg

/* File: umc_modem.sv */
// modem control and modem status logic of one UART channel
// assumes: single clock, plain register port, modem pins asynchronous,
// transmit data and flow-control request come from logic on this clock
`timescale 1ns/1ps
`default_nettype none
`include "umc_regs.svh"

module umc_modem #(
  parameter int PRESCALE_DIV = `UMC_PRESC_DIV
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [`UMC_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rd_data_o,
  // modem pins, active low
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  output logic rts_n_o,
  output logic dtr_n_o,
  output logic general_purpose_out_n_o,
  // serial path
  input wire logic rx_pin_i,
  input wire logic tx_i,
  output logic rx_o,
  // flow control engine
  input wire logic flow_rts_i,
  // controls to the rest of the channel
  output logic baud_clk_en_o,
  output logic threshold_sel_o,
  output logic xon_any_o,
  output logic fifo_rdy_en_o,
  output logic loopback_o,
  // interrupts
  output logic irq_o,
  output logic modem_irq_o
);
  import umc_pkg::*;

  // ===========================================================
  // elaboration checks
  if (PRESCALE_DIV < 2 || PRESCALE_DIV > 256) begin : g_bad_div
    $error("umc_modem: PRESCALE_DIV must lie in 2..256");
  end

  localparam logic [7:0] CNT_LAST = 8'(PRESCALE_DIV - 1);

  // ===========================================================
  // helpers
  function automatic logic [`UMC_NLN-1:0] umc_changed(
    input logic [`UMC_NLN-1:0] now,
    input logic [`UMC_NLN-1:0] old
  );
    logic [`UMC_NLN-1:0] ch;
    ch = now ^ old;
    ch[`UMC_LN_RI] = now[`UMC_LN_RI] & ~old[`UMC_LN_RI];
    return ch;
  endfunction : umc_changed

  function automatic logic [`UMC_NLN-1:0] umc_sticky(
    input logic [`UMC_NLN-1:0] cur,
    input logic [`UMC_NLN-1:0] clr,
    input logic [`UMC_NLN-1:0] set
  );
    return (cur & ~clr) | set;
  endfunction : umc_sticky

  // ===========================================================
  // state
  umc_state_type r;
  umc_state_type next_r;

  logic loop_on;
  logic [`UMC_NLN-1:0] lb_lines;
  logic [`UMC_NLN-1:0] level;
  logic [`UMC_NLN-1:0] active;
  logic [`UMC_NLN-1:0] chg;
  logic [7:0] msr_val;
  logic wr_mcr;
  logic rd_msr;
  logic [`UMC_NLN-1:0] ist_clr;
  logic [7:0] mcr_wr;
  logic cnt_wrap;

  // ===========================================================
  // modem status view
  always_comb begin
    loop_on = r.modem_control[`UMC_MCR_LOOP];
    lb_lines = {r.modem_control[`UMC_MCR_GPO], r.modem_control[`UMC_MCR_FRDY],
                r.modem_control[`UMC_MCR_DTR], r.modem_control[`UMC_MCR_RTS]}; // see RULE6
    if (loop_on) begin
      level = lb_lines;
      active = lb_lines; // see RULE6
    end else begin
      level = r.sync[`UMC_NLN-1:0]; // see RULE18
      active = ~r.sync[`UMC_NLN-1:0]; // see RULE12
    end
    chg = umc_changed(level, r.prev); // see RULE13 RULE14 RULE15 RULE16
    msr_val = {active, r.delta};
  end

  // ===========================================================
  // register port decode
  always_comb begin
    wr_mcr = wr_i && (addr_i == `UMC_ADDR_MCR);
    rd_msr = rd_i && (addr_i == `UMC_ADDR_MSR);
    ist_clr = '0;
    if (wr_i && (addr_i == `UMC_ADDR_IST)) begin
      ist_clr = wr_data_i[`UMC_NLN-1:0];
    end
    mcr_wr = wr_data_i;
    if (!r.cfg[`UMC_CFG_EFR_WE]) begin
      mcr_wr[`UMC_MCR_PROT_HI:`UMC_MCR_PROT_LO] =
        r.modem_control[`UMC_MCR_PROT_HI:`UMC_MCR_PROT_LO]; // see RULE4
    end
    cnt_wrap = (r.cnt == CNT_LAST);
  end

  // ===========================================================
  // next state
  always_comb begin
    next_r = r;

    // pin synchronisers, first stage feeds only the second
    next_r.meta = {rx_pin_i, cd_n_i, ri_n_i, dsr_n_i, cts_n_i}; // see RULE18
    next_r.sync = r.meta; // see RULE18
    next_r.prev = level;

    // control and configuration writes
    if (wr_mcr) begin
      next_r.modem_control = mcr_wr; // see RULE4
    end
    if (wr_i && (addr_i == `UMC_ADDR_CFG)) begin
      next_r.cfg = wr_data_i[`UMC_CFG_W-1:0];
    end
    if (wr_i && (addr_i == `UMC_ADDR_IMSK)) begin
      next_r.imask = wr_data_i[`UMC_NLN-1:0];
    end

    // change flags: a status read or an interrupt status write clears, a new change wins
    next_r.delta = umc_sticky(r.delta, {`UMC_NLN{rd_msr}}, chg); // see RULE13 RULE14 RULE15 RULE16
    next_r.ist = umc_sticky(r.ist, ist_clr, chg);

    // read data, one cycle after the strobe
    next_r.rd_data = `UMC_RST_BYTE;
    if (rd_i) begin
      case (addr_i)
        `UMC_ADDR_MCR: next_r.rd_data = r.modem_control;
        `UMC_ADDR_MSR: next_r.rd_data = msr_val;
        `UMC_ADDR_CFG: next_r.rd_data = 8'({r.cfg});
        `UMC_ADDR_IST: next_r.rd_data = 8'({r.ist});
        `UMC_ADDR_IMSK: next_r.rd_data = 8'({r.imask});
        default: next_r.rd_data = `UMC_RST_BYTE;
      endcase
    end

    // input clock prescaler
    if (r.modem_control[`UMC_MCR_CLKSEL]) begin
      next_r.cnt = cnt_wrap ? `UMC_RST_CNT : r.cnt + 8'h01; // see RULE1
      next_r.baud_en = cnt_wrap; // see RULE1
    end else begin
      next_r.cnt = `UMC_RST_CNT;
      next_r.baud_en = 1'b1; // see RULE1
    end

    // modem outputs
    if (r.cfg[`UMC_CFG_AUTORTS]) begin
      next_r.rts_n = ~flow_rts_i; // see RULE10
    end else begin
      next_r.rts_n = ~r.modem_control[`UMC_MCR_RTS]; // see RULE9
    end
    next_r.dtr_n = ~r.modem_control[`UMC_MCR_DTR]; // see RULE11
    next_r.gpo_n = ~r.modem_control[`UMC_MCR_GPO]; // see RULE7

    // controls to the channel
    next_r.tcr_sel = r.modem_control[`UMC_MCR_TCRSEL]; // see RULE2
    next_r.xon_any = r.modem_control[`UMC_MCR_XONANY]; // see RULE3
    next_r.frdy_en = r.modem_control[`UMC_MCR_FRDY]; // see RULE8
    next_r.loop = loop_on; // see RULE5
    next_r.rx = loop_on ? tx_i : r.sync[`UMC_LN_RX]; // see RULE5

    // interrupts
    next_r.irq = |(r.ist & r.imask);
    next_r.modem_irq = r.cfg[`UMC_CFG_IER_MS] & (|r.delta); // see RULE17
  end

  // ===========================================================
  // state register
  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      r.modem_control <= `UMC_RST_MCR;
      r.cfg <= `UMC_RST_CFG;
      r.delta <= `UMC_RST_NIB;
      r.ist <= `UMC_RST_NIB;
      r.imask <= `UMC_RST_NIB;
      r.meta <= `UMC_RST_SYNC;
      r.sync <= `UMC_RST_SYNC;
      r.prev <= `UMC_RST_LVL;
      r.cnt <= `UMC_RST_CNT;
      r.rts_n <= 1'b1;
      r.dtr_n <= 1'b1;
      r.gpo_n <= 1'b1;
      r.baud_en <= 1'b0;
      r.tcr_sel <= 1'b0;
      r.xon_any <= 1'b0;
      r.frdy_en <= 1'b0;
      r.loop <= 1'b0;
      r.rx <= 1'b1;
      r.rd_data <= `UMC_RST_BYTE;
      r.irq <= 1'b0;
      r.modem_irq <= 1'b0;
    end else begin
      r <= next_r;
    end
  end

  // ===========================================================
  // outputs
  assign rd_data_o = r.rd_data;
  assign rts_n_o = r.rts_n;
  assign dtr_n_o = r.dtr_n;
  assign general_purpose_out_n_o = r.gpo_n;
  assign rx_o = r.rx;
  assign baud_clk_en_o = r.baud_en;
  assign threshold_sel_o = r.tcr_sel;
  assign xon_any_o = r.xon_any;
  assign fifo_rdy_en_o = r.frdy_en;
  assign loopback_o = r.loop;
  assign irq_o = r.irq;
  assign modem_irq_o = r.modem_irq;

endmodule : umc_modem

`default_nettype wire

/* File: umc_modem_sva.sv */
// port checker of the modem control block
// assumes: bound to umc_modem, one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module umc_modem_sva (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rd_data_o,
  input wire logic cts_n_i,
  input wire logic dsr_n_i,
  input wire logic ri_n_i,
  input wire logic cd_n_i,
  input wire logic dtr_n_o,
  input wire logic general_purpose_out_n_o,
  input wire logic threshold_sel_o,
  input wire logic xon_any_o,
  input wire logic fifo_rdy_en_o,
  input wire logic loopback_o,
  input wire logic irq_o,
  input wire logic modem_irq_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  wire logic ctl_wr = wr_i && addr_i == 3'h0;
  sequence s_calm;
    (!wr_i && $stable({cts_n_i, dsr_n_i, ri_n_i, cd_n_i}))[*6];
  endsequence
  sequence s_stat_rd;
    rd_i && addr_i == 3'h1;
  endsequence
  a_dtr_follow: assert property (ctl_wr |-> ##2 dtr_n_o == !$past(wr_data_i[0], 2))
    else $error("dtr output differs from control bit");
  a_gpo_follow: assert property (ctl_wr |-> ##2 general_purpose_out_n_o == !$past(wr_data_i[3], 2))
    else $error("general output differs from control bit");
  a_loop_follow: assert property (ctl_wr |-> ##2 loopback_o == $past(wr_data_i[4], 2))
    else $error("loopback differs from control bit");
  a_ctl_guard: assert property ($changed({xon_any_o, threshold_sel_o, fifo_rdy_en_o}) && $past(resetn_i)
    |-> $past(wr_i, 2) && $past(addr_i, 2) == 3'h0) else $error("control output moved without a write");
  a_rd_once: assert property (!$past(rd_i) |-> rd_data_o == 8'h00)
    else $error("read data outside the answer cycle");
  a_stat_clear: assert property (s_calm ##0 s_stat_rd ##1 s_calm ##0 s_stat_rd |=> rd_data_o[3:0] == 4'h0)
    else $error("change flag reported twice");
  a_irq_fall: assert property ($fell(irq_o) && $past(resetn_i)
    |-> $past(wr_i, 2) && $past(addr_i, 2) inside {3'h3, 3'h4}) else $error("irq dropped without clear");
  a_mirq_fall: assert property ($fell(modem_irq_o) && $past(resetn_i) |-> $past(rd_i, 2) &&
    $past(addr_i, 2) == 3'h1 || $past(wr_i, 2) && $past(addr_i, 2) == 3'h2) else $error("modem irq dropped");
endmodule : umc_modem_sva
`default_nettype wire

/* File: umc_modem_model.sv */
// modem side: drives the four active-low handshake inputs
// assumes: levels commanded by the bench, reaching the pins 1 to 4 cycles late
`timescale 1ns/1ps
`default_nettype none
module umc_modem_model (
  input wire logic clk_i,
  input wire logic [3:0] want_i,
  input wire logic [1:0] lag_i,
  output logic [3:0] pins_o
);
  logic [3:0] dly [4] = '{default: 4'hF};
  always @(posedge clk_i) begin
    dly[0] <= want_i;
    for (int i = 1; i < 4; i++) dly[i] <= dly[i-1];
  end
  assign pins_o = dly[lag_i];
endmodule : umc_modem_model
`default_nettype wire

/* File: tb_top.sv */
// self-checking bench of the modem control block
// assumes: design, modem model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam int DIV = 4;
  logic ref_clk_i = 0, resetn_i = 0, wr_i = 0, rd_i = 0, tx_i = 0, rx_pin_i = 1, flow_rts_i = 0;
  logic [2:0] addr_i = 0, cfg = 0;
  logic [7:0] wr_data_i = 0, rd_data_o, q, modem_control = 0;
  logic [3:0] want = 4'hF, raw = 4'hF, dlt = 0, ist = 0, msk = 0, w;
  logic [1:0] lag = 0;
  logic [31:0] seed = 64;
  wire logic cts_n_i, dsr_n_i, ri_n_i, cd_n_i;
  logic rts_n_o, dtr_n_o, general_purpose_out_n_o, rx_o, baud_clk_en_o, threshold_sel_o;
  logic xon_any_o, fifo_rdy_en_o, loopback_o, irq_o, modem_irq_o;
  int miscompares = 0, num_checks = 0, n, k;
  wire logic [7:0] ctl_seen = {1'b0, general_purpose_out_n_o, rts_n_o, dtr_n_o, threshold_sel_o, xon_any_o,
    loopback_o, fifo_rdy_en_o};
  always #2.5 ref_clk_i = ~ref_clk_i;
  umc_modem_model MDL (.clk_i(ref_clk_i), .want_i(want), .lag_i(lag), .pins_o({cd_n_i, ri_n_i, dsr_n_i, cts_n_i}));
  umc_modem #(.PRESCALE_DIV(DIV)) DUT (.ref_clk_i, .resetn_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o,
    .cts_n_i, .dsr_n_i, .ri_n_i, .cd_n_i, .rts_n_o, .dtr_n_o, .general_purpose_out_n_o, .rx_pin_i, .tx_i,
    .rx_o, .flow_rts_i, .baud_clk_en_o, .threshold_sel_o, .xon_any_o, .fifo_rdy_en_o, .loopback_o, .irq_o,
    .modem_irq_o);
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge ref_clk_i) begin
      addr_i <= a;
      wr_data_i <= d;
      wr_i <= 1;
    end
    @(posedge ref_clk_i) wr_i <= 0;
  endtask : wrr
  task automatic rdr(input logic [2:0] a);
    @(posedge ref_clk_i) begin
      addr_i <= a;
      rd_i <= 1;
    end
    @(posedge ref_clk_i) rd_i <= 0;
    @(negedge ref_clk_i) q = rd_data_o;
  endtask : rdr
  // protected bits keep their value without the feature enable
  task automatic wmcr(input logic [7:0] d);
    wrr(3'h0, d);
    modem_control = cfg[0] ? d : {modem_control[7:5], d[4:0]};
  endtask : wmcr
  // new source levels; ring flag only on a low to high source
  task automatic upd(input logic fresh);
    logic [3:0] nr, d;
    nr = modem_control[4] ? {modem_control[3], modem_control[2], modem_control[0], modem_control[1]} : want;
    d = ((raw ^ nr) & 4'hB) | {1'b0, ~raw[2] & nr[2], 2'b0};
    if (!fresh) dlt |= d;
    if (!fresh) ist |= d;
    raw = nr;
  endtask : upd
  // after a mode change the flags are flushed
  task automatic clr();
    rdr(3'h1);
    wrr(3'h3, 8'h0F);
    dlt = 0;
    ist = 0;
    upd(1);
  endtask : clr
  task automatic stat();
    rdr(3'h1);
    chk("status", {modem_control[4] ? raw : ~raw, dlt}, q);
    dlt = 0;
  endtask : stat
  task automatic cko();
    chk("ctrl outs", {1'b0, !modem_control[3], cfg[2] ? !flow_rts_i : !modem_control[1], !modem_control[0], modem_control[6:4], modem_control[2]}, ctl_seen);
  endtask : cko
  task automatic stop_test();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : stop_test
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    stop_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk_i);
    resetn_i <= 1;
    rdr(3'h0);
    chk("mcr reset", 8'h00, q);
    rdr(3'h7);
    chk("unmapped", 8'h00, q);
    for (n = 0; n < 16; n++) begin
      cfg = 3'(xs());
      @(posedge ref_clk_i) flow_rts_i <= 1'(xs());
      wrr(3'h2, {5'h0, cfg});
      wmcr(8'(xs()) & 8'hEF);
      rdr(3'h0);
      chk("mcr", modem_control, q);
      cko();
    end
    cfg = 3'h1;
    wrr(3'h2, 8'h01);
    for (n = 0; n < 2; n++) begin
      wmcr(n ? 8'h00 : 8'h80);
      repeat (4) @(posedge ref_clk_i);
      k = 0;
      repeat (40) @(negedge ref_clk_i) k += baud_clk_en_o;
      chk("baud ticks", n ? 8'h28 : 8'(40 / DIV), 8'(k));
    end
    for (n = 0; n < 20; n++) begin
      cfg = {1'b0, 1'(xs()), 1'b1};
      msk = 4'(xs());
      w = 4'(xs());
      wrr(3'h2, {5'h0, cfg});
      wrr(3'h4, {4'h0, msk});
      wrr(3'h3, {4'h0, w});
      ist &= ~w;
      @(posedge ref_clk_i) begin
        want <= 4'(xs());
        lag <= 2'(xs());
        rx_pin_i <= 1'(xs());
      end
      repeat (10) @(posedge ref_clk_i);
      upd(0);
      @(negedge ref_clk_i);
      chk("irqs", {6'h0, |(ist & msk), cfg[1] & |dlt}, {6'h0, irq_o, modem_irq_o});
      chk("rx pin", {7'h0, rx_pin_i}, {7'h0, rx_o});
      rdr(3'h3);
      chk("int status", {4'h0, ist}, q);
      stat();
      repeat (4) @(posedge ref_clk_i);
      stat();
    end
    for (n = 0; n < 10; n++) begin
      wmcr(8'h10 | 8'(xs() & 15));
      if (n == 0) clr();
      else upd(0);
      stat();
      @(posedge ref_clk_i) tx_i <= 1'(xs());
      repeat (2) @(negedge ref_clk_i);
      chk("rx loop", {7'h0, tx_i}, {7'h0, rx_o});
      cko();
    end
    wmcr(8'h00);
    clr();
    wrr(3'h1, 8'hFF);
    stat();
    stop_test();
  end
endmodule : tb_top
bind umc_modem umc_modem_sva SVA (.ref_clk_i, .resetn_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .cts_n_i,
  .dsr_n_i, .ri_n_i, .cd_n_i, .dtr_n_o, .general_purpose_out_n_o, .threshold_sel_o, .xon_any_o, .fifo_rdy_en_o,
  .loopback_o, .irq_o, .modem_irq_o);
`default_nettype wire
